// ===== rtl/pla_jk_sequencer.sv
// programmable logic sequencer with j-k/d flops and axi4-lite fuse access
//
// Behaviour
// - four flops fed by 32 logic product terms plus 13 control terms
// - base variant also has eight combinational i/o pins from the array
// - every variant has twelve outputs, registered plus combinational
// - state and combinational values reach pins through inverting buffers
// - all outputs feed back to the array in true and complement form
// - each flop individually selectable as j-k or d type
// - both preload terms plus a clock load inverted pin values into the flops
// - base variant: preset/reset in two banks of two, from sum terms
// - output enable pin with bank terms gates flops 0-1 and 2-3
// - each combinational output has its own three-state product term
// - each combinational output has a programmable xor polarity stage
// - all flops clocked together from one clock
// - six-flop variant trades two combinational outputs for two flops
// - six-flop: flops 0-3 sum-term preset/reset, flops 4-5 product terms
// - eight-flop: two banks of four, preset/reset from product terms
// - eight-flop variant presents inverted flop outputs at the pins
`timescale 1ns/1ps
module pla_jk_sequencer #(
    parameter int NUM_FLOPS = 4
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic [sequencer_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                             awvalid,
    output wire logic                             awready,
    input  wire logic [sequencer_pkg::DATA_W-1:0] wdata,
    input  wire logic [sequencer_pkg::STRB_W-1:0] wstrb,
    input  wire logic                             wvalid,
    output wire logic                             wready,
    output wire logic [1:0]                       bresp,
    output wire logic                             bvalid,
    input  wire logic                             bready,
    input  wire logic [sequencer_pkg::ADDR_W-1:0] araddr,
    input  wire logic                             arvalid,
    output wire logic                             arready,
    output wire logic [sequencer_pkg::DATA_W-1:0] rdata,
    output wire logic [1:0]                       rresp,
    output wire logic                             rvalid,
    input  wire logic                             rready,
    input  wire logic [sequencer_pkg::NUM_INPUTS-1:0] inputPins,
    input  wire logic [sequencer_pkg::NUM_PINS-1:0]   pinIn,
    input  wire logic                             outEnableN,
    output wire logic [sequencer_pkg::NUM_PINS-1:0]   pinOut,
    output wire logic [sequencer_pkg::NUM_PINS-1:0]   pinOeN
);
    import sequencer_pkg::*;

    localparam int NUM_COMB = NUM_PINS - NUM_FLOPS;

    function automatic region_t regionOf(input logic [ADDR_W-1:0] a);
        if (a < MEM_SPAN)
            regionOf = REGION_MEM;
        else if (a == CONFIG_ADDR)
            regionOf = REGION_CONFIG;
        else if (a == STATUS_ADDR)
            regionOf = REGION_STATUS;
        else
            regionOf = REGION_NONE;
    endfunction

    // an empty mask means an unused term, held low
    function automatic logic termValue(input logic [DATA_W-1:0] mask,
                                       input logic [DATA_W-1:0] lits);
        termValue = (|mask) & (&(lits | ~mask));
    endfunction

    // pin inputs cross in through two flops
    logic [NUM_VARS:0]        sync1_q;
    logic [NUM_VARS:0]        sync2_q;
    logic [NUM_PINS-1:0]      pinSync;
    logic [NUM_INPUTS-1:0]    inSync;
    logic                     oeNSync;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
        end
        else
        begin
            sync1_q <= {outEnableN, inputPins, pinIn};
            sync2_q <= sync1_q;
        end
    end

    assign pinSync = sync2_q[NUM_PINS-1:0];
    assign inSync  = sync2_q[NUM_VARS-1:NUM_PINS];
    assign oeNSync = sync2_q[NUM_VARS];

    // bus side registers
    logic                   awHeld_q;
    logic                   wHeld_q;
    logic [ADDR_W-1:0]      awAddr_q;
    logic [DATA_W-1:0]      wData_q;
    logic [STRB_W-1:0]      wStrb_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rdPend_q;
    logic [ADDR_W-1:0]      arAddr_q;
    logic                   rvalid_q;
    logic [1:0]             rresp_q;
    logic [DATA_W-1:0]      rdata_q;
    logic [CFG_W-1:0]       config_q;
    logic [MAX_FLOPS-1:0]   flop_q;
    logic                   doWrite;
    region_t                wRegion;

    term_store_if #(.WIDTH(DATA_W), .DEPTH(MEM_DEPTH), .AW(MEM_AW)) store();

    term_store #(
        .WIDTH (DATA_W),
        .DEPTH (MEM_DEPTH)
    ) u_store (
        .clk (clk),
        .rst (rst),
        .mem (store)
    );

    assign awready = !awHeld_q && !bvalid_q;
    assign wready  = !wHeld_q && !bvalid_q;
    assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
    assign wRegion = regionOf(awAddr_q);

    always_ff @(posedge clk)
    begin
        if (rst)
            awHeld_q <= 1'b0;
        else if (awvalid && awready)
            awHeld_q <= 1'b1;
        else if (doWrite)
            awHeld_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            awAddr_q <= '0;
        else if (awvalid && awready)
            awAddr_q <= awaddr;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end
        else if (wvalid && wready)
        begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end
        else if (doWrite)
            wHeld_q <= 1'b0;
    end

    // status is read only; a write to it is accepted and dropped
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wRegion == REGION_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bready)
            bvalid_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            config_q <= CFG_RESET;
        else if (doWrite && wRegion == REGION_CONFIG)
        begin
            for (int b = 0; b < CFG_W / BYTE_W; b++)
                if (wStrb_q[b])
                    config_q[b*BYTE_W +: BYTE_W] <= wData_q[b*BYTE_W +: BYTE_W];
        end
    end

    assign store.we    = doWrite && (wRegion == REGION_MEM);
    assign store.waddr = awAddr_q[WORD_LSB +: MEM_AW];
    assign store.wdata = wData_q;
    assign store.wstrb = wStrb_q;
    assign store.re    = arvalid && arready;
    assign store.raddr = araddr[WORD_LSB +: MEM_AW];

    // reads take two edges so the store's registered word can be muxed
    assign arready = !rdPend_q && !rvalid_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdPend_q <= 1'b0;
            arAddr_q <= '0;
        end
        else if (arvalid && arready)
        begin
            rdPend_q <= 1'b1;
            arAddr_q <= araddr;
        end
        else
            rdPend_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end
        else if (rdPend_q)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
            case (regionOf(arAddr_q))
                REGION_MEM:    rdata_q <= store.rdata;
                REGION_CONFIG: rdata_q[CFG_W-1:0] <= config_q;
                REGION_STATUS:
                begin
                    rdata_q[ST_FLOP_LSB +: MAX_FLOPS] <= flop_q;
                    rdata_q[ST_PIN_LSB +: NUM_PINS]   <= pinSync;
                    rdata_q[ST_OE_BIT]                <= oeNSync;
                end
                default:       rresp_q <= RESP_SLVERR;
            endcase
        end
        else if (rready)
            rvalid_q <= 1'b0;
    end

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp  = rresp_q;
    assign rdata  = rdata_q;

    // array evaluation
    logic [NUM_VARS-1:0]        vars;
    logic [DATA_W-1:0]          lits;
    logic [NUM_TERMS-1:0]       terms;
    logic [NUM_LOGIC_TERMS-1:0] logicTerms;
    logic [NUM_CTRL_TERMS-1:0]  ctrlTerms;
    logic [NUM_SUMS-1:0]        sums;
    logic [NUM_PINS-1:0]        pinNext;
    logic [NUM_PINS-1:0]        driveNext;
    logic [MAX_FLOPS-1:0]       setReq;
    logic [MAX_FLOPS-1:0]       clrReq;
    logic                       preload;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_pin
            if (g < NUM_FLOPS)
            begin : g_reg
                assign vars[g]      = flop_q[g];
                // pin shows the inverted state in every variant
                assign pinNext[g]   = ~flop_q[g];
                assign driveNext[g] = !oeNSync &&
                    ((g < 2) ? ctrlTerms[CT_BANK_A_DRIVE]
                             : ctrlTerms[CT_BANK_B_DRIVE]);
            end
            else
            begin : g_comb
                assign vars[g]      = pinSync[g];
                assign pinNext[g]   = ~(sums[SUM_COMB_BASE + g - NUM_FLOPS]
                    ^ config_q[CFG_POL_LSB + g - NUM_FLOPS]);
                assign driveNext[g] =
                    ctrlTerms[CT_DRIVE_BASE + g - NUM_FLOPS];
            end
        end
        for (g = NUM_FLOPS; g < MAX_FLOPS; g++)
        begin : g_pad
            assign setReq[g] = 1'b0;
            assign clrReq[g] = 1'b0;
        end
    endgenerate

    assign vars[NUM_VARS-1:NUM_PINS] = inSync;
    assign lits = {~vars, vars};

    generate
        for (g = 0; g < NUM_TERMS; g++)
        begin : g_term
            assign terms[g] = termValue(store.flat[g*DATA_W +: DATA_W], lits);
        end
        for (g = 0; g < NUM_SUMS; g++)
        begin : g_sum
            assign sums[g] = |(logicTerms &
                store.flat[(OR_BASE_IDX + g)*DATA_W +: DATA_W]);
        end
    endgenerate

    assign logicTerms = terms[NUM_LOGIC_TERMS-1:0];
    assign ctrlTerms  = terms[NUM_TERMS-1:NUM_LOGIC_TERMS];
    assign preload    = ctrlTerms[CT_PRELOAD_A] &&
                        ctrlTerms[CT_PRELOAD_B];

    // banked preset/reset per variant; freed drive terms are reused
    generate
        for (g = 0; g < NUM_FLOPS; g++)
        begin : g_bank
            if (NUM_FLOPS == MAX_FLOPS)
            begin : g_eight
                assign setReq[g] = (g < 4) ? ctrlTerms[CT_SET_LO8]
                                           : ctrlTerms[CT_SET_HI8];
                assign clrReq[g] = (g < 4) ? ctrlTerms[CT_CLR_LO8]
                                           : ctrlTerms[CT_CLR_HI8];
            end
            else if (NUM_FLOPS > 4)
            begin : g_six
                assign setReq[g] = (g < 4) ? sums[SUM_SET_A]
                                           : ctrlTerms[CT_SET_B6];
                assign clrReq[g] = (g < 4) ? sums[SUM_CLR_A]
                                           : ctrlTerms[CT_CLR_B6];
            end
            else
            begin : g_four
                assign setReq[g] = (g < 2) ? sums[SUM_SET_A]
                                           : sums[SUM_SET_B];
                assign clrReq[g] = (g < 2) ? sums[SUM_CLR_A]
                                           : sums[SUM_CLR_B];
            end
        end
    endgenerate

    // preload beats clear beats set beats the j/k inputs
    always_ff @(posedge clk)
    begin
        if (rst)
            flop_q <= '0;
        else
        begin
            for (int k = 0; k < NUM_FLOPS; k++)
            begin
                if (preload)
                    flop_q[k] <= ~pinSync[k];
                else if (clrReq[k])
                    flop_q[k] <= 1'b0;
                else if (setReq[k])
                    flop_q[k] <= 1'b1;
                else if (config_q[CFG_MODE_LSB + k])
                    flop_q[k] <= sums[2*k];
                else
                    case ({sums[2*k], sums[2*k+1]})
                        2'b10:   flop_q[k] <= 1'b1;
                        2'b01:   flop_q[k] <= 1'b0;
                        2'b11:   flop_q[k] <= ~flop_q[k];
                        default: flop_q[k] <= flop_q[k];
                    endcase
            end
            for (int k = NUM_FLOPS; k < MAX_FLOPS; k++)
                flop_q[k] <= 1'b0;
        end
    end

    // pins re-timed one edge so outputs come from flops
    logic [NUM_PINS-1:0] pinOut_q;
    logic [NUM_PINS-1:0] pinOeN_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pinOut_q <= '0;
            pinOeN_q <= '1;
        end
        else
        begin
            pinOut_q <= pinNext;
            pinOeN_q <= ~driveNext;
        end
    end

    assign pinOut = pinOut_q;
    assign pinOeN = pinOeN_q;
endmodule // pla_jk_sequencer

// ===== rtl/sequencer_pkg.sv
// constants, register map and array layout for the logic sequencer
package sequencer_pkg;
    localparam int DATA_W          = 32;
    localparam int ADDR_W          = 12;
    localparam int BYTE_W          = 8;
    localparam int STRB_W          = DATA_W / BYTE_W;
    localparam int WORD_LSB        = 2;
    localparam int NUM_PINS        = 12;
    localparam int NUM_INPUTS      = 4;
    localparam int NUM_VARS        = NUM_PINS + NUM_INPUTS;
    localparam int NUM_LOGIC_TERMS = 32;
    localparam int NUM_CTRL_TERMS  = 13;
    localparam int NUM_TERMS       = NUM_LOGIC_TERMS + NUM_CTRL_TERMS;
    localparam int NUM_SUMS        = 28;
    localparam int MAX_FLOPS       = 8;
    localparam int MEM_DEPTH       = 128;
    localparam int MEM_AW          = 7;
    localparam int OR_BASE_IDX     = 64;
    // register byte addresses
    localparam logic [ADDR_W-1:0] MEM_SPAN    = 12'h200;
    localparam logic [ADDR_W-1:0] CONFIG_ADDR = 12'h200;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h204;
    // sum indices: j/k pairs at 2k and 2k+1, then outputs and bank terms
    localparam int SUM_COMB_BASE   = 16;
    localparam int SUM_SET_A       = 24;
    localparam int SUM_CLR_A       = 25;
    localparam int SUM_SET_B       = 26;
    localparam int SUM_CLR_B       = 27;
    // control term indices
    localparam int CT_PRELOAD_A    = 0;
    localparam int CT_PRELOAD_B    = 1;
    localparam int CT_BANK_A_DRIVE = 2;
    localparam int CT_BANK_B_DRIVE = 3;
    localparam int CT_DRIVE_BASE   = 4;
    localparam int CT_SET_B6       = 10;
    localparam int CT_CLR_B6       = 11;
    localparam int CT_SET_LO8      = 8;
    localparam int CT_CLR_LO8      = 9;
    localparam int CT_SET_HI8      = 10;
    localparam int CT_CLR_HI8      = 11;
    // config and status fields
    localparam int CFG_MODE_LSB    = 0;
    localparam int CFG_POL_LSB     = 8;
    localparam int CFG_W           = 16;
    localparam int ST_FLOP_LSB     = 0;
    localparam int ST_PIN_LSB      = 8;
    localparam int ST_OE_BIT       = 20;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
    localparam logic [NUM_VARS:0] SYNC_RESET = 17'h10000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        REGION_MEM,
        REGION_CONFIG,
        REGION_STATUS,
        REGION_NONE
    } region_t;
endpackage

// ===== rtl/term_store.sv
// word store for and/or array masks, registered read port
`timescale 1ns/1ps
module term_store #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 128
) (
    input wire logic    clk,
    input wire logic    rst,
    term_store_if.store mem
);
    import sequencer_pkg::*;

    logic [WIDTH-1:0] words_q [DEPTH];
    logic [WIDTH-1:0] rdata_q;

    // cleared on reset so an unprogrammed array drives nothing
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                words_q[i] <= '0;
        end
        else if (mem.we)
        begin
            for (int b = 0; b < WIDTH / BYTE_W; b++)
                if (mem.wstrb[b])
                    words_q[mem.waddr][b*BYTE_W +: BYTE_W] <=
                        mem.wdata[b*BYTE_W +: BYTE_W];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_q <= '0;
        else if (mem.re)
            rdata_q <= words_q[mem.raddr];
    end

    assign mem.rdata = rdata_q;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_flat
            assign mem.flat[g*WIDTH +: WIDTH] = words_q[g];
        end
    endgenerate
endmodule // term_store

// ===== rtl/term_store_if.sv
// signals between the sequencer and its array fuse store
`timescale 1ns/1ps
interface term_store_if #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 128,
    parameter int AW    = 7
);
    logic                   we;
    logic [AW-1:0]          waddr;
    logic [WIDTH-1:0]       wdata;
    logic [WIDTH/8-1:0]     wstrb;
    logic                   re;
    logic [AW-1:0]          raddr;
    logic [WIDTH-1:0]       rdata;
    logic [DEPTH*WIDTH-1:0] flat;

    modport store (input we, waddr, wdata, wstrb, re, raddr,
                   output rdata, flat);
    modport user  (output we, waddr, wdata, wstrb, re, raddr,
                   input rdata, flat);
endinterface

// ===== test/pin_partner.sv
// pin-side system model: resolves each pin from both drivers
`timescale 1ns/1ps
module pin_partner (
    input  wire logic        clk,
    input  wire logic [11:0] pinOut,
    input  wire logic [11:0] pinOeN,
    input  wire logic [11:0] extVal,
    input  wire logic        extEn,
    output      logic [11:0] pinIn
);
    logic [11:0] wiggle_q = 12'hA5A;
    // no pull on these pins, so a floating pin never holds a level
    always @(posedge clk)
        wiggle_q <= ~wiggle_q;
    // system drives only pins the device has released
    always_comb
        for (int i = 0; i < 12; i++)
            pinIn[i] = !pinOeN[i] ? pinOut[i]
                     : (extEn ? extVal[i] : wiggle_q[i]);
endmodule // pin_partner

// ===== test/pla_jk_sequencer_checker.sv
// bus and pin timing checker for the logic sequencer
`timescale 1ns/1ps
module pla_jk_sequencer_checker #(
    parameter int NUM_FLOPS = 4
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [11:0] araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        outEnableN,
    input wire logic [11:0] pinOeN
);
    import sequencer_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_bresp_stands: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp)) else $error("write response dropped");
    a_rdata_stands: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped");
    a_write_answer: assert property (awvalid && awready && wvalid &&
        wready |=> !bvalid ##1 bvalid) else $error("write answer late");
    a_read_answer: assert property (arvalid && arready |=>
        !rvalid ##1 rvalid) else $error("read answer late");
    a_write_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answering");
    a_read_refused: assert property (rvalid |-> !arready)
        else $error("read taken while answering");
    a_unmapped_read: assert property (arvalid && arready &&
        araddr >= 12'h208 |=> ##1 rresp == RESP_SLVERR && rdata == '0)
        else $error("unmapped read not refused");
    // sync plus output register costs three edges, five gives margin
    a_flop_oe_off: assert property (outEnableN [*5] |->
        &pinOeN[NUM_FLOPS-1:0]) else $error("flop pin driven while off");

    c_write: cover property (awvalid && awready && wvalid && wready);
    c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
    c_bank_on: cover property (!pinOeN[0] && pinOeN[2]);
endmodule // pla_jk_sequencer_checker

bind pla_jk_sequencer pla_jk_sequencer_checker #(.NUM_FLOPS(NUM_FLOPS))
    checker_i (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .outEnableN(outEnableN), .pinOeN(pinOeN));

// ===== test/pla_jk_sequencer_tb_top.sv
// self-checking bench for the logic sequencer, base variant
`timescale 1ns/1ps
module pla_jk_sequencer_tb_top;
    import sequencer_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
    logic        clk = 1'b0, rst = 1'b1;
    logic [11:0] awaddr = '0, araddr = '0, pinIn, pinOut, pinOeN;
    logic [11:0] extVal = '0;
    logic [31:0] wdata = '0, rdata, rng = 32'h0000D0C8, v;
    logic [3:0]  wstrb = '0, inputPins = '0;
    logic [1:0]  bresp, rresp;
    logic        awvalid = 0, wvalid = 0, arvalid = 0, bready = 1;
    logic        rready = 1, outEnableN = 1, extEn = 0, t0;
    logic        awready, wready, bvalid, arready, rvalid;
    note_t       rdQ[$];
    logic [1:0]  wrQ[$];
    int          failures = 0, checkCount = 0, cycles = 0;
    logic [11:0] ma [9] = '{12'h000, 12'h004, 12'h100, 12'h104, 12'h140,
                            12'h090, 12'h088, 12'h160, 12'h164};
    logic [31:0] md [9] = '{32'h1000, 32'h2000, 32'h1, 32'h2, 32'h1,
                            32'h4000, 32'h8000, 32'h1, 32'h2};

    always #5 clk = ~clk;

    pla_jk_sequencer #(.NUM_FLOPS(4)) pla_jk_sequencer_i (.clk(clk),
        .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .inputPins(inputPins),
        .pinIn(pinIn), .outEnableN(outEnableN), .pinOut(pinOut),
        .pinOeN(pinOeN));
    pin_partner pin_partner_i (.clk(clk), .pinOut(pinOut),
        .pinOeN(pinOeN), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic compare(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        checkCount++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] r);
        logic aDone;
        logic wDone;
        aDone = 0;
        wDone = 0;
        wrQ.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        while (!(aDone && wDone))
        begin
            @(posedge clk);
            if (awvalid && awready)
            begin
                aDone = 1;
                awvalid <= 0;
            end
            if (wvalid && wready)
            begin
                wDone = 1;
                wvalid <= 0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] d,
                            input logic [31:0] m, input logic [1:0] r);
        rdQ.push_back('{d, m, r});
        araddr <= a;
        arvalid <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge clk); while (rvalid !== 1'b1);
    endtask

    // six edges cover the two-flop sync, the flop step and the pin register
    task automatic drive_in(input logic [3:0] p);
        inputPins <= p;
        repeat (6) @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (bvalid && bready && wrQ.size() > 0)
            compare("bresp", 32'(wrQ.pop_front()), 32'(bresp));
        if (rvalid && rready && rdQ.size() > 0)
        begin
            compare("rdata", rdQ[0].d, rdata & rdQ[0].m);
            compare("rresp", 32'(rdQ[0].r), 32'(rresp));
            void'(rdQ.pop_front());
        end
        if (cycles == 5000)
        begin
            failures++;
            finish_test();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        axi_read(CONFIG_ADDR, 32'h0, 32'hFFFF, RESP_OKAY);
        rng = next_rand(rng);
        axi_write(12'h1F0, rng, 4'hF, RESP_OKAY);
        axi_write(12'h1F0, 32'hFF, 4'h1, RESP_OKAY);
        axi_read(12'h1F0, {rng[31:8], 8'hFF}, '1, RESP_OKAY);
        axi_write(12'h208, 32'h1, 4'hF, RESP_SLVERR);
        axi_read(12'hFFC, 32'h0, '1, RESP_SLVERR);
        $display("registers done");
        for (int i = 0; i < 7; i++)
            axi_write(ma[i], md[i], 4'hF, RESP_OKAY);
        drive_in(4'h1);
        axi_read(STATUS_ADDR, 32'h1, 32'h1, RESP_OKAY);
        drive_in(4'h0);
        axi_read(STATUS_ADDR, 32'h1, 32'h1, RESP_OKAY);
        drive_in(4'h2);
        axi_read(STATUS_ADDR, 32'h0, 32'h1, RESP_OKAY);
        drive_in(4'h3);
        t0 = pinOut[0];
        @(posedge clk);
        compare("toggle", {31'h0, ~t0}, 32'(pinOut[0]));
        $display("jk mode done");
        axi_write(CONFIG_ADDR, 32'h1, 4'hF, RESP_OKAY);
        repeat (4) @(posedge clk);
        compare("dflop", 32'h0, 32'(pinOut[0]));
        @(posedge clk);
        compare("dflop", 32'h0, 32'(pinOut[0]));
        drive_in(4'h2);
        axi_read(STATUS_ADDR, 32'h0, 32'h1, RESP_OKAY);
        drive_in(4'h5);
        compare("comb", 32'h0, 32'(pinOut[4]));
        compare("combOe", 32'h0, 32'(pinOeN[4]));
        axi_write(CONFIG_ADDR, 32'h101, 4'hF, RESP_OKAY);
        repeat (6) @(posedge clk);
        compare("comb", 32'h1, 32'(pinOut[4]));
        axi_read(STATUS_ADDR, 32'h1000, 32'h1000, RESP_OKAY);
        drive_in(4'h1);
        compare("combOe", 32'h1, 32'(pinOeN[4]));
        outEnableN <= 0;
        drive_in(4'h8);
        compare("bankOe", 32'hC, 32'(pinOeN[3:0]));
        drive_in(4'h0);
        compare("bankOe", 32'hF, 32'(pinOeN[3:0]));
        outEnableN <= 1;
        $display("outputs done");
        axi_write(CONFIG_ADDR, 32'h0, 4'hF, RESP_OKAY);
        for (int i = 7; i < 9; i++)
            axi_write(ma[i], md[i], 4'hF, RESP_OKAY);
        drive_in(4'h1);
        axi_read(STATUS_ADDR, 32'h3, 32'hF, RESP_OKAY);
        drive_in(4'h3);
        axi_read(STATUS_ADDR, 32'h0, 32'hF, RESP_OKAY);
        drive_in(4'h0);
        rng = next_rand(rng);
        v = rng;
        extVal <= v[11:0];
        extEn <= 1;
        axi_write(12'h080, 32'h80000000, 4'hF, RESP_OKAY);
        axi_write(12'h084, 32'h80000000, 4'hF, RESP_OKAY);
        repeat (6) @(posedge clk);
        axi_read(STATUS_ADDR, {28'h0, ~v[3:0]}, 32'hF, RESP_OKAY);
        $display("preset and preload done");
        @(posedge clk);
        finish_test();
    end
endmodule // pla_jk_sequencer_tb_top
